/* hdl/dac_ctrl_params.svh */
// constants of the dac control register bank
// assumes inclusion by the package and the design files
`ifndef DAC_CTRL_PARAMS_SVH
`define DAC_CTRL_PARAMS_SVH

`define WORD_BITS 16
`define ADDR_HI 15
`define ADDR_LO 12
`define DATA_HI 9
`define ADDR_POWER_INTERP 4'h0
`define ADDR_MUTE 4'h1
`define ADDR_VOLUME_FIRST 4'h2
`define ADDR_VOLUME_LAST 4'h7
`define ADDR_CLOCK_REPL 4'h8
`define POWER_DOWN_BIT 2
`define INTERP_HI 1
`define INTERP_LO 0
`define MUTE_HI 5
`define REPLICATE_BIT 5
`define MCLK_HI 4
`define MCLK_LO 3
`define ZERO_POL_BIT 2
`define CHANNELS 6
`define SAMPLE_BITS 24
`define VOLUME_BITS 10
`define VOLUME_RESET 10'h3FF
`define ZERO_RUN 11'h400
`define ATTEN_SHIFT 10
`define ONE_BIT 1'h1
`define GAIN_ONE 11'h001
`define ZERO_COUNT_ONE 11'h001

`endif

/* hdl/dac_ctrl_pkg.sv */
// types of the dac control register bank
// assumes the params header is on the include path
`include "dac_ctrl_params.svh"

package dac_ctrl_pkg;

    typedef logic [`VOLUME_BITS-1:0] volume_t;
    typedef logic signed [`SAMPLE_BITS-1:0] sample_t;

    // interpolation rate codes
    typedef enum logic [1:0] {
        INTERP_8X = 2'h0,
        INTERP_2X = 2'h1,
        INTERP_4X = 2'h2,
        INTERP_RESERVED = 2'h3
    } interp_e;

    // master clock ratio codes
    typedef enum logic [1:0] {
        MCLK_256 = 2'h0,
        MCLK_512 = 2'h1,
        MCLK_768 = 2'h2,
        MCLK_RESERVED = 2'h3
    } mclk_e;

    // one volume write toward the store
    typedef struct packed {
        logic write;
        logic [2:0] index;
        volume_t value;
    } volume_write_s;

    // received audio of all channels
    typedef struct packed {
        logic strobe;
        sample_t [`CHANNELS-1:0] sample;
    } audio_in_s;

    // state of the control bank
    typedef struct packed {
        logic [`WORD_BITS-1:0] shift_reg;
        logic shift_clock_reg;
        logic latch_reg;
        logic pd_pending_reg;
        logic power_down_reg;
        interp_e interp_reg;
        logic [`CHANNELS-1:0] mute_reg;
        logic replicate_reg;
        mclk_e mclk_reg;
        logic zero_pol_reg;
        logic [`CHANNELS-1:0][10:0] zero_count_reg;
        logic [`CHANNELS-1:0] zero_flag_reg;
        logic zero_all_reg;
        logic clock_double_reg;
        logic clock_div3_reg;
        logic out_strobe_reg;
        sample_t [`CHANNELS-1:0] out_reg;
    } bank_state_s;

    // state of the volume store
    typedef struct packed {
        volume_t [`CHANNELS-1:0] word_reg;
    } store_state_s;

endpackage : dac_ctrl_pkg

/* hdl/volume_store.sv */
// six-word volume memory with registered read words
// assumes one writer, synchronous reset on the system clock
`timescale 1ns/10ps
`include "dac_ctrl_params.svh"

module volume_store
    import dac_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input volume_write_s wr,
    output volume_t [`CHANNELS-1:0] words
);

    store_state_s s_reg;
    store_state_s s_next;

    // write the addressed word only
    always_comb begin
        s_next = s_reg;
        if (wr.write) begin
            s_next.word_reg[wr.index] = wr.value;
        end
    end

    // reset to no attenuation
    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= {`CHANNELS{`VOLUME_RESET}};
        end else begin
            s_reg <= s_next;
        end
    end

    assign words = s_reg.word_reg;

endmodule : volume_store

/* hdl/dac_ctrl_bank.sv */
// control register bank of a six-channel audio dac
// assumes control port pins and audio inputs synchronous to SYS_CLK
`timescale 1ns/10ps
`include "dac_ctrl_params.svh"

module dac_ctrl_bank
    import dac_ctrl_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic CONTROL_SHIFT_CLOCK,
    input wire logic CONTROL_DATA,
    input wire logic CONTROL_LATCH_STROBE,
    input audio_in_s AUDIO_IN,
    output logic POWER_DOWN,
    output interp_e INTERP_RATE,
    output mclk_e MCLK_RATIO,
    output logic CLOCK_DOUBLE,
    output logic CLOCK_DIV3,
    output logic [`CHANNELS-1:0] CHANNEL_MUTE,
    output logic STEREO_REPLICATE,
    output logic [`CHANNELS-1:0] ZERO_FLAG,
    output logic ZERO_ALL,
    output logic AUDIO_OUT_STROBE,
    output sample_t [`CHANNELS-1:0] AUDIO_OUT
);

    bank_state_s s_reg;
    bank_state_s s_next;
    volume_write_s vol_wr;
    volume_t [`CHANNELS-1:0] volume;
    sample_t [`CHANNELS-1:0] routed;
    sample_t [`CHANNELS-1:0] scaled;
    logic [3:0] word_addr;
    logic [`DATA_HI:0] word_data;
    logic latch_rise;
    logic shift_rise;

    // true for the six volume addresses
    function automatic logic is_volume(input logic [3:0] addr);
        is_volume = (addr >= `ADDR_VOLUME_FIRST) && (addr <= `ADDR_VOLUME_LAST);
    endfunction : is_volume

    // channel index of a volume address
    function automatic logic [2:0] volume_index(input logic [3:0] addr);
        logic [3:0] diff;
        diff = addr - `ADDR_VOLUME_FIRST;
        volume_index = diff[2:0];
    endfunction : volume_index

    // edges of the control port pins
    assign shift_rise = CONTROL_SHIFT_CLOCK && !s_reg.shift_clock_reg;
    assign latch_rise = CONTROL_LATCH_STROBE && !s_reg.latch_reg;
    assign word_addr = s_reg.shift_reg[`ADDR_HI:`ADDR_LO];
    assign word_data = s_reg.shift_reg[`DATA_HI:0];

    always_comb begin
        vol_wr.write = latch_rise && is_volume(word_addr);
        vol_wr.index = volume_index(word_addr);
        vol_wr.value = word_data;
    end

    volume_store u_volume_store (
        .clk(SYS_CLK),
        .reset(RESET),
        .wr(vol_wr),
        .words(volume)
    );

    // per-channel routing and attenuation
    generate
        for (genvar ch = 0; ch < `CHANNELS; ch++) begin : g_chan
            logic [`VOLUME_BITS:0] gain;
            logic signed [`SAMPLE_BITS+`VOLUME_BITS+1:0] product;
            // pairs 2 and 3 take pair 1 data
            if (ch >= 2) begin : g_repl
                assign routed[ch] = s_reg.replicate_reg ? AUDIO_IN.sample[ch % 2]
                                                        : AUDIO_IN.sample[ch];
            end else begin : g_own
                assign routed[ch] = AUDIO_IN.sample[ch];
            end
            // gain of volume plus one, full scale passes unchanged
            assign gain = {1'b0, volume[ch]} + `GAIN_ONE;
            assign product = routed[ch] * $signed({1'b0, gain});
            assign scaled[ch] = product[`SAMPLE_BITS+`ATTEN_SHIFT-1:`ATTEN_SHIFT];
        end
    endgenerate

    // next state of the bank
    always_comb begin
        logic all_zero;
        all_zero = 1'b1;
        s_next = s_reg;
        s_next.shift_clock_reg = CONTROL_SHIFT_CLOCK;
        s_next.latch_reg = CONTROL_LATCH_STROBE;
        // msb first shift on shift clock rise
        if (shift_rise) begin
            s_next.shift_reg = {s_reg.shift_reg[`WORD_BITS-2:0], CONTROL_DATA};
        end
        if (latch_rise) begin
            // apply the power-down value held from the last power and interpolation word
            s_next.power_down_reg = s_reg.pd_pending_reg;
            case (word_addr)
                `ADDR_POWER_INTERP: begin
                    s_next.pd_pending_reg = word_data[`POWER_DOWN_BIT];
                    s_next.interp_reg = interp_e'(word_data[`INTERP_HI:`INTERP_LO]);
                end
                `ADDR_MUTE: begin
                    s_next.mute_reg = word_data[`MUTE_HI:0];
                end
                // clock, replicate and zero polarity register
                `ADDR_CLOCK_REPL: begin
                    s_next.replicate_reg = word_data[`REPLICATE_BIT];
                    s_next.mclk_reg = mclk_e'(word_data[`MCLK_HI:`MCLK_LO]);
                    s_next.zero_pol_reg = word_data[`ZERO_POL_BIT];
                end
                default: begin
                end
            endcase
        end
        // internal clock path from the ratio code
        case (s_reg.mclk_reg)
            MCLK_256: begin
                s_next.clock_double_reg = 1'b1;
                s_next.clock_div3_reg = 1'b0;
            end
            MCLK_768: begin
                s_next.clock_double_reg = 1'b1;
                s_next.clock_div3_reg = 1'b1;
            end
            default: begin
                s_next.clock_double_reg = 1'b0;
                s_next.clock_div3_reg = 1'b0;
            end
        endcase
        s_next.out_strobe_reg = AUDIO_IN.strobe;
        for (int ch = 0; ch < `CHANNELS; ch++) begin
            if (AUDIO_IN.strobe) begin
                if (AUDIO_IN.sample[ch] != '0) begin
                    s_next.zero_count_reg[ch] = '0;
                // saturate at the zero run length
                end else if (s_reg.zero_count_reg[ch] != `ZERO_RUN) begin
                    s_next.zero_count_reg[ch] = s_reg.zero_count_reg[ch] + `ZERO_COUNT_ONE;
                end
                // mute forces silence on that channel
                s_next.out_reg[ch] = s_reg.mute_reg[ch] ? '0 : scaled[ch];
            end
            // flag once the run is reached
            all_zero = all_zero && (s_next.zero_count_reg[ch] == `ZERO_RUN);
            s_next.zero_flag_reg[ch] =
                (s_next.zero_count_reg[ch] == `ZERO_RUN) ^ s_reg.zero_pol_reg;
        end
        // global flag when every channel is zero
        s_next.zero_all_reg = all_zero ^ s_reg.zero_pol_reg;
    end

    // reset clears every field, mute off
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign POWER_DOWN = s_reg.power_down_reg;
    assign INTERP_RATE = s_reg.interp_reg;
    assign MCLK_RATIO = s_reg.mclk_reg;
    assign CLOCK_DOUBLE = s_reg.clock_double_reg;
    assign CLOCK_DIV3 = s_reg.clock_div3_reg;
    assign CHANNEL_MUTE = s_reg.mute_reg;
    assign STEREO_REPLICATE = s_reg.replicate_reg;
    assign ZERO_FLAG = s_reg.zero_flag_reg;
    assign ZERO_ALL = s_reg.zero_all_reg;
    assign AUDIO_OUT_STROBE = s_reg.out_strobe_reg;
    assign AUDIO_OUT = s_reg.out_reg;

endmodule : dac_ctrl_bank

/* verif/dac_ctrl_bank_checker.sv */
// port assertions of the dac control bank
// assumes package and params header compiled first
`timescale 1ns/10ps
`include "dac_ctrl_params.svh"

module dac_ctrl_bank_checker
    import dac_ctrl_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic CONTROL_LATCH_STROBE,
    input audio_in_s AUDIO_IN,
    input logic POWER_DOWN,
    input interp_e INTERP_RATE,
    input mclk_e MCLK_RATIO,
    input logic CLOCK_DOUBLE,
    input logic CLOCK_DIV3,
    input logic [`CHANNELS-1:0] CHANNEL_MUTE,
    input logic STEREO_REPLICATE,
    input logic [`CHANNELS-1:0] ZERO_FLAG,
    input logic ZERO_ALL,
    input logic AUDIO_OUT_STROBE,
    input sample_t [`CHANNELS-1:0] AUDIO_OUT
);
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);

    // audio path timing and mute
    a_out_strobe: assert property (AUDIO_IN.strobe |=> AUDIO_OUT_STROBE)
        else $error("output strobe missing");
    a_out_hold: assert property (!AUDIO_IN.strobe |=> !AUDIO_OUT_STROBE && $stable(AUDIO_OUT))
        else $error("audio out moved without strobe");
    a_mute_zero: assert property (AUDIO_IN.strobe && CHANNEL_MUTE[0] |=> AUDIO_OUT[0] == '0)
        else $error("muted channel not silent");
    // control fields move only after a latch, clock selects follow the previous ratio
    a_ctrl_hold: assert property ($changed({POWER_DOWN, INTERP_RATE, MCLK_RATIO, CHANNEL_MUTE,
        STEREO_REPLICATE}) |-> $past(CONTROL_LATCH_STROBE) || $past(CONTROL_LATCH_STROBE, 2))
        else $error("control field changed without latch");
    a_clock_double: assert property (!$past(RESET) |->
        CLOCK_DOUBLE == ($past(MCLK_RATIO) inside {MCLK_256, MCLK_768}))
        else $error("doubler select wrong");
    a_clock_divide: assert property (!$past(RESET) |->
        CLOCK_DIV3 == ($past(MCLK_RATIO) == MCLK_768))
        else $error("divider select wrong");
    // zero status
    a_zero_hold: assert property ($changed(ZERO_FLAG) |-> $past(AUDIO_IN.strobe)
        || $past(CONTROL_LATCH_STROBE) || $past(CONTROL_LATCH_STROBE, 2))
        else $error("zero flag moved without cause");
    a_zero_all_on: assert property (ZERO_FLAG == '1 |-> ZERO_ALL)
        else $error("global zero not matching channels");
    a_zero_all_off: assert property (ZERO_FLAG == '0 |-> !ZERO_ALL)
        else $error("global zero not matching channels");
endmodule : dac_ctrl_bank_checker

bind dac_ctrl_bank dac_ctrl_bank_checker u_dac_ctrl_bank_checker (.SYS_CLK(SYS_CLK),
    .RESET(RESET), .CONTROL_LATCH_STROBE(CONTROL_LATCH_STROBE), .AUDIO_IN(AUDIO_IN),
    .POWER_DOWN(POWER_DOWN), .INTERP_RATE(INTERP_RATE), .MCLK_RATIO(MCLK_RATIO),
    .CLOCK_DOUBLE(CLOCK_DOUBLE), .CLOCK_DIV3(CLOCK_DIV3), .CHANNEL_MUTE(CHANNEL_MUTE),
    .STEREO_REPLICATE(STEREO_REPLICATE), .ZERO_FLAG(ZERO_FLAG), .ZERO_ALL(ZERO_ALL),
    .AUDIO_OUT_STROBE(AUDIO_OUT_STROBE), .AUDIO_OUT(AUDIO_OUT));

/* verif/ctrl_host_model.sv */
// host side of the serial control port
// assumes pins sampled on clk, each level held two cycles
`timescale 1ns/10ps

module ctrl_host_model (
    input wire logic clk,
    input wire logic start,
    input wire logic [15:0] word,
    output logic busy = 1'h0,
    output logic sclk = 1'h0,
    output logic sdat = 1'h0,
    output logic latch = 1'h0
);
    always begin
        @(posedge clk);
        if (start) begin
            busy <= 1'h1;
            for (int i = 15; i >= 0; i--) begin
                sclk <= 1'h0;
                sdat <= word[i];
                repeat (2) @(posedge clk);
                sclk <= 1'h1;
                repeat (2) @(posedge clk);
            end
            sclk <= 1'h0;
            sdat <= ~word[0];
            repeat (2) @(posedge clk);
            latch <= 1'h1;
            repeat (2) @(posedge clk);
            latch <= 1'h0;
            busy <= 1'h0;
        end
    end
endmodule : ctrl_host_model

/* verif/tb.sv */
// self-checking bench of the dac control bank
// assumes package, params header and checker compiled first
`timescale 1ns/10ps
`include "dac_ctrl_params.svh"

module tb import dac_ctrl_pkg::*;;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic start = 1'h0;
    logic [15:0] word = 16'h0000;
    logic busy, sclk, sdat, latch, pd, dbl, div3, rep_o, zall, ostb;
    interp_e irate;
    mclk_e mrat;
    logic [5:0] mute_o, zflag;
    audio_in_s ain = '0;
    sample_t [5:0] aout, s;
    volume_t vol [6];
    logic [5:0] mute = 6'h00;
    logic rep = 1'h0;
    int fail_count = 0;
    int checks_done = 0;

    dac_ctrl_bank u_dac_ctrl_bank (.SYS_CLK(clk), .RESET(rst), .CONTROL_SHIFT_CLOCK(sclk),
        .CONTROL_DATA(sdat), .CONTROL_LATCH_STROBE(latch), .AUDIO_IN(ain), .POWER_DOWN(pd),
        .INTERP_RATE(irate), .MCLK_RATIO(mrat), .CLOCK_DOUBLE(dbl), .CLOCK_DIV3(div3),
        .CHANNEL_MUTE(mute_o), .STEREO_REPLICATE(rep_o), .ZERO_FLAG(zflag), .ZERO_ALL(zall),
        .AUDIO_OUT_STROBE(ostb), .AUDIO_OUT(aout));
    ctrl_host_model u_ctrl_host_model (.clk(clk), .start(start), .word(word), .busy(busy),
        .sclk(sclk), .sdat(sdat), .latch(latch));

    // 125 MHz clock
    always #4 clk = ~clk;

    function automatic sample_t ex(sample_t x, volume_t v, logic m);
        logic signed [34:0] p;
        p = x * $signed({2'h0, v} + 12'h001);
        return m ? '0 : sample_t'(p >>> 10);
    endfunction : ex

    task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // one control word, reserved bits zero
    task automatic wr(logic [3:0] a, logic [9:0] d);
        int n;
        n = 0;
        @(posedge clk);
        start <= 1'h1;
        word <= {a, 2'h0, d};
        @(posedge clk);
        start <= 1'h0;
        repeat (2) @(posedge clk);
        while (busy && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n == 200) begin
            fail_count++;
            report_and_stop();
        end
        repeat (2) @(posedge clk);
        #1;
    endtask : wr

    task automatic send(logic c);
        sample_t e;
        @(posedge clk);
        ain.strobe <= 1'h1;
        ain.sample <= s;
        @(posedge clk);
        ain.strobe <= 1'h0;
        ain.sample <= ~s;
        #1;
        if (c) begin
            for (int k = 0; k < 6; k++) begin
                e = ex(rep && k > 1 ? s[k % 2] : s[k], vol[k], mute[k]);
                chk("audio_out", aout[k], e);
            end
            chk("out_strobe", ostb, 1'h1);
        end
    endtask : send

    // main sequence
    initial begin
        void'($urandom(96599));
        foreach (vol[k]) vol[k] = 10'h3FF;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        repeat (2) @(posedge clk);
        chk("reset", {pd, irate, mrat, mute_o, rep_o, zflag, zall}, '0);
        wr(4'h0, 10'h004);
        chk("power_down", pd, 1'h0);
        wr(4'h0, 10'h004);
        chk("power_down", pd, 1'h1);
        for (int c = 0; c < 4; c++) begin
            wr(4'h0, 10'(c));
            chk("interp", irate, c[1:0]);
        end
        chk("power_down", pd, 1'h0);
        for (int c = 0; c < 4; c++) begin
            wr(4'h8, 10'(c << 3));
            chk("mclk", {mrat, dbl, div3}, {c[1:0], c == 0 || c == 2, c == 2});
        end
        for (int a = 9; a < 16; a++) begin
            wr(4'(a), 10'($urandom));
            chk("reserved", {irate, mrat, mute_o, rep_o, pd}, {4'hF, 8'h00});
        end
        // reset volumes pass audio unattenuated, untouched by reserved writes
        foreach (s[k]) s[k] = 24'($urandom);
        send(1'h1);
        for (int k = 0; k < 6; k++) begin
            vol[k] = k == 0 ? 10'h000 : 10'($urandom);
            wr(4'(k + 2), vol[k]);
        end
        for (int r = 0; r < 4; r++) begin
            rep = r[1];
            mute = r == 0 ? 6'h00 : 6'($urandom) | 6'h01;
            wr(4'h8, {4'h0, rep, 5'h00});
            wr(4'h1, {4'h0, mute});
            chk("mute", {mute_o, rep_o}, {mute, rep});
            foreach (s[k]) s[k] = 24'($urandom);
            send(1'h1);
        end
        s = '0;
        repeat (1023) send(1'h0);
        chk("zero_early", {zflag, zall}, 7'h00);
        send(1'h1);
        chk("zero_all", {zflag, zall}, 7'h7F);
        s[0] = 24'h000001;
        s[1] = 24'hFFFFFF;
        send(1'h1);
        chk("zero_raw", {zflag, zall}, 7'h78);
        wr(4'h8, 10'h024);
        chk("zero_pol", {zflag, zall}, 7'h07);
        report_and_stop();
    end
endmodule : tb
